//--- verilog/hall_cfg_pkg.sv
// Package with register map, field layout, defaults and timing for the output configuration block
`default_nettype none
package hall_cfg_pkg;
	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [7:0] OFS_MAIN_CLAMP = 8'h00;
	localparam logic [7:0] OFS_SUB_CLAMP = 8'h04;
	localparam logic [7:0] OFS_MAIN_TEMP = 8'h08;
	localparam logic [7:0] OFS_SUB_TEMP = 8'h0C;
	localparam logic [7:0] OFS_PROTOCOL = 8'h10;
	localparam logic [7:0] OFS_USER = 8'h14;
	localparam logic [7:0] OFS_PROG_CMD = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;
	localparam int NV_WORDS = 6;
	localparam int NV_PAGES = 3;
	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CLAMP_LOW_LSB = 0;
	localparam int CLAMP_HIGH_LSB = 16;
	localparam int T0_LSB = 0;
	localparam int TC1_LSB = 8;
	localparam int TC2_LSB = 20;
	localparam int ID_BIT = 0;
	localparam int SLEW_BIT = 1;
	localparam int DELAY_LSB = 8;
	localparam int CMD_LSB = 0;
	localparam int PAGE_LSB = 4;
	localparam int ST_REJECT_BIT = 4;
	// ************************************************************
	// Reset values of the nonvolatile words
	// ************************************************************
	localparam logic [12:0] CLAMP_LOW_DEF = 13'h0199;
	localparam logic [12:0] CLAMP_HIGH_DEF = 13'h1E65;
	localparam logic [6:0] T0_DEF = 7'h19;
	localparam logic [9:0] TC1_DEF = 10'h13B;
	localparam logic [8:0] TC2_DEF = 9'h100;
	localparam logic [7:0] DELAY_DEF = 8'h10;
	localparam logic [31:0] CLAMP_WORD_DEF = {3'h0, CLAMP_HIGH_DEF, 3'h0, CLAMP_LOW_DEF};
	localparam logic [31:0] TEMP_WORD_DEF = {3'h0, TC2_DEF, 2'h0, TC1_DEF, 1'h0, T0_DEF};
	localparam logic [31:0] PROTO_WORD_DEF = {16'h0000, DELAY_DEF, 8'h00};
	localparam logic [31:0] MAP_MASK_CLAMP = 32'h1FFF1FFF;
	localparam logic [31:0] MAP_MASK_TEMP = 32'h1FF3FF7F;
	localparam logic [31:0] MAP_MASK_PROTO = 32'h0000FF03;
	// ************************************************************
	// Compensation arithmetic
	// ************************************************************
	localparam logic signed [10:0] TC1_ZERO = 11'sh13B;
	localparam logic signed [9:0] TC2_ZERO = 10'sh100;
	localparam int FAC_FRAC = 23;
	localparam int LIN_SHIFT = 6;
	localparam logic signed [29:0] FAC_UNITY = 30'sh0080_0000;
	localparam logic signed [21:0] ZERO_POINT = 22'sh000FFF;
	// ************************************************************
	// Commands and timing
	// ************************************************************
	localparam logic [2:0] CMD_ACTIVATE = 3'h1;
	localparam logic [2:0] CMD_PAGE_PROGRAM = 3'h2;
	localparam logic [2:0] CMD_MARGIN = 3'h3;
	localparam logic [2:0] CMD_LOCK = 3'h4;
	localparam logic [2:0] CMD_EXIT = 3'h5;
	localparam int CLOCK_MHZ = 200;
	localparam int US_CYCLES = CLOCK_MHZ * 1;
	localparam logic [8:0] MIN_DELAY_US = 9'h02C;
	localparam int ACTIVATE_WINDOW_US = 10000;
	typedef enum logic [2:0] {ST_NORMAL, ST_PROG, ST_PAGE_OPEN, ST_PAGE_ARMED, ST_MARGIN_ARMED,
		ST_LOCK_ARMED} prog_state_type;
endpackage
`default_nettype wire

//--- verilog/hall_output_config.sv
// Output configuration, signal clamping, frame delay and nonvolatile programming control
`timescale 1ns/1ps
`default_nettype none
module hall_output_config
	import hall_cfg_pkg::*;
#(
	parameter int ACTIVATE_WINDOW_CYCLES = ACTIVATE_WINDOW_US * US_CYCLES
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic signed [13:0] main_meas,
	input wire logic signed [13:0] sub_meas,
	input wire logic [7:0] die_temp,
	input wire logic sync_pin,
	input wire logic prog_pulse_pin,
	output logic [12:0] main_out,
	output logic [12:0] sub_out,
	output logic frame_id_bit,
	output logic slew_slow,
	output logic frame_start
);
	// ************************************************************
	// Signal path: temperature compensation and clamping
	// ************************************************************
	function automatic logic [12:0] comp_clamp(input logic signed [13:0] meas, input logic [7:0] temp,
		input logic [31:0] tw, input logic [31:0] cw);
		logic signed [8:0] dt;
		logic signed [10:0] tc1d;
		logic signed [9:0] tc2d;
		logic signed [17:0] sq;
		logic signed [19:0] lin;
		logic signed [27:0] quad;
		logic signed [29:0] fac;
		logic signed [43:0] prod;
		logic signed [21:0] sum;
		logic signed [21:0] lo;
		logic signed [21:0] hi;
		dt = $signed({1'b0, temp}) - $signed({2'b00, tw[T0_LSB +: 7]});
		tc1d = $signed({1'b0, tw[TC1_LSB +: 10]}) - TC1_ZERO;
		tc2d = $signed({1'b0, tw[TC2_LSB +: 9]}) - TC2_ZERO;
		sq = dt * dt;
		lin = tc1d * dt;
		quad = tc2d * sq;
		fac = FAC_UNITY + (30'(lin) <<< LIN_SHIFT) + 30'(quad);
		prod = 44'(meas) * 44'(fac);
		sum = 22'(prod >>> FAC_FRAC) + ZERO_POINT;
		lo = $signed({9'h000, cw[CLAMP_LOW_LSB +: 13]});
		hi = $signed({9'h000, cw[CLAMP_HIGH_LSB +: 13]});
		// Saturate as the final stage
		if (sum < lo) begin
			comp_clamp = lo[12:0];
		end else if (sum > hi) begin
			comp_clamp = hi[12:0];
		end else begin
			comp_clamp = sum[12:0];
		end
	endfunction

	// ************************************************************
	// Storage, synchronisers and state
	// ************************************************************
	logic [31:0] nv_r [NV_WORDS];
	logic [31:0] stage_r [NV_WORDS];
	prog_state_type state_r;
	logic [1:0] page_r;
	logic locked_r;
	logic margin_done_r;
	logic prog_done_r;
	logic reject_r;
	logic window_open_r;
	logic [31:0] window_cnt_r;
	logic [2:0] sync_sr_r;
	logic [2:0] pulse_sr_r;
	logic delay_run_r;
	logic [7:0] us_cnt_r;
	logic [8:0] delay_cnt_r;
	logic [12:0] main_out_r;
	logic [12:0] sub_out_r;
	logic frame_start_r;

	// ************************************************************
	// APB decode
	// ************************************************************
	wire logic acc = psel & penable;
	wire logic wr = acc & pwrite;
	wire logic [2:0] word_idx = paddr[4:2];
	wire logic is_cfg = (paddr <= OFS_USER) & (paddr[1:0] == 2'b00);
	wire logic is_cmd = (paddr == OFS_PROG_CMD);
	wire logic is_stat = (paddr == OFS_STATUS);
	wire logic [1:0] word_page = 2'(word_idx >> 1);
	wire logic cfg_ok = (state_r == ST_PAGE_OPEN) & (word_page == page_r) & ~locked_r;
	wire logic cfg_wr = wr & is_cfg & cfg_ok;
	wire logic cfg_bad = wr & is_cfg & ~cfg_ok;
	wire logic cmd_wr = wr & is_cmd;
	wire logic [2:0] cmd = pwdata[CMD_LSB +: 3];
	wire logic [1:0] cmd_page = pwdata[PAGE_LSB +: 2];
	wire logic unmapped = ~(is_cfg | is_cmd | is_stat);
	wire logic [31:0] cfg_mask = (word_idx < 3'h4) ? (word_idx[1] ? MAP_MASK_TEMP : MAP_MASK_CLAMP) :
		(word_idx == 3'h4) ? MAP_MASK_PROTO : 32'hFFFFFFFF;
	wire logic [31:0] status_word = {26'h0, window_open_r, reject_r, prog_done_r, margin_done_r,
		locked_r, (state_r != ST_NORMAL)};
	wire logic pulse_rise = pulse_sr_r[1] & ~pulse_sr_r[2];
	wire logic sync_rise = sync_sr_r[1] & ~sync_sr_r[2];
	wire logic page_cmd = cmd_wr & (cmd == CMD_PAGE_PROGRAM);
	wire logic page_refused = page_cmd & (locked_r | (cmd_page >= 2'(NV_PAGES)));
	wire logic lock_refused = cmd_wr & (cmd == CMD_LOCK) & locked_r;
	wire logic reject_set = cfg_bad | page_refused | lock_refused;

	// APB answers at once; reads of config show the live nonvolatile words
	assign pready = 1'b1;
	assign pslverr = acc & (unmapped | cfg_bad | page_refused);
	assign prdata = (acc & ~pwrite & is_cfg) ? nv_r[word_idx] :
		(acc & ~pwrite & is_stat) ? status_word : 32'h00000000;

	// ************************************************************
	// Programming sequence
	// ************************************************************
	prog_state_type state_nxt;
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_NORMAL: begin
				if (cmd_wr & (cmd == CMD_ACTIVATE) & window_open_r) begin
					state_nxt = ST_PROG;
				end
			end
			ST_PROG: begin
				if (page_cmd & ~page_refused) begin
					state_nxt = ST_PAGE_OPEN;
				end else if (cmd_wr & (cmd == CMD_MARGIN)) begin
					state_nxt = ST_MARGIN_ARMED;
				end else if (cmd_wr & (cmd == CMD_LOCK) & ~locked_r) begin
					state_nxt = ST_LOCK_ARMED;
				end else if (cmd_wr & (cmd == CMD_EXIT)) begin
					state_nxt = ST_NORMAL;
				end
			end
			ST_PAGE_OPEN: begin
				if (page_cmd & ~page_refused & (cmd_page == page_r)) begin
					state_nxt = ST_PAGE_ARMED;
				end else if (cmd_wr & (cmd == CMD_EXIT)) begin
					state_nxt = ST_NORMAL;
				end
			end
			ST_PAGE_ARMED, ST_MARGIN_ARMED, ST_LOCK_ARMED: begin
				if (pulse_rise) begin
					state_nxt = ST_PROG;
				end
			end
			default: begin
				state_nxt = ST_NORMAL;
			end
		endcase
	end

	// Sequence state and page pointer
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_NORMAL;
			page_r <= 2'h0;
		end else begin
			state_r <= state_nxt;
			if ((state_r == ST_PROG) & page_cmd & ~page_refused) begin
				page_r <= cmd_page;
			end
		end
	end

	// Status flags; hardware set wins over software clear
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			locked_r <= 1'b0;
			margin_done_r <= 1'b0;
			prog_done_r <= 1'b0;
			reject_r <= 1'b0;
		end else begin
			if ((state_r == ST_LOCK_ARMED) & pulse_rise) begin
				locked_r <= 1'b1;
			end
			if ((state_r == ST_MARGIN_ARMED) & pulse_rise) begin
				margin_done_r <= 1'b1;
			end
			if ((state_r == ST_PAGE_ARMED) & pulse_rise) begin
				prog_done_r <= 1'b1;
			end else if (page_cmd) begin
				prog_done_r <= 1'b0;
			end
			if (reject_set) begin
				reject_r <= 1'b1;
			end else if (wr & is_stat & pwdata[ST_REJECT_BIT]) begin
				reject_r <= 1'b0;
			end
		end
	end

	// Activation window after power-on
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			window_cnt_r <= 32'h00000000;
			window_open_r <= 1'b1;
		end else if (window_open_r) begin
			window_cnt_r <= window_cnt_r + 32'h00000001;
			window_open_r <= (window_cnt_r < 32'(ACTIVATE_WINDOW_CYCLES - 1));
		end
	end

	// Staging loads from the page on selection, nonvolatile words burn on the pulse
	genvar gi;
	generate
		for (gi = 0; gi < NV_WORDS; gi++) begin : g_word
			localparam logic [31:0] DEF = (gi < 2) ? CLAMP_WORD_DEF : (gi < 4) ? TEMP_WORD_DEF :
				(gi == 4) ? PROTO_WORD_DEF : 32'h00000000;
			localparam logic [1:0] PG = 2'(gi / 2);
			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst) begin
					stage_r[gi] <= DEF;
					nv_r[gi] <= DEF;
				end else begin
					if ((state_r == ST_PROG) & page_cmd & ~page_refused & (cmd_page == PG)) begin
						stage_r[gi] <= nv_r[gi];
					end else if (cfg_wr & (word_idx == 3'(gi))) begin
						stage_r[gi] <= pwdata & cfg_mask;
					end
					if ((state_r == ST_PAGE_ARMED) & pulse_rise & (page_r == PG) & ~locked_r) begin
						nv_r[gi] <= stage_r[gi];
					end
				end
			end
		end
	endgenerate

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sync_sr_r <= 3'h0;
			pulse_sr_r <= 3'h0;
		end else begin
			sync_sr_r <= {sync_sr_r[1:0], sync_pin};
			pulse_sr_r <= {pulse_sr_r[1:0], prog_pulse_pin};
		end
	end

	// ************************************************************
	// Sync to first frame delay
	// ************************************************************
	wire logic [8:0] delay_target = MIN_DELAY_US + {1'b0, nv_r[4][DELAY_LSB +: 8]};
	wire logic us_tick = (us_cnt_r == 8'(US_CYCLES - 1));
	wire logic delay_hit = delay_run_r & us_tick & (delay_cnt_r == delay_target - 9'h001);
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			delay_run_r <= 1'b0;
			us_cnt_r <= 8'h00;
			delay_cnt_r <= 9'h000;
			frame_start_r <= 1'b0;
		end else begin
			frame_start_r <= delay_hit;
			if (sync_rise) begin
				delay_run_r <= 1'b1;
				us_cnt_r <= 8'h00;
				delay_cnt_r <= 9'h000;
			end else if (delay_run_r) begin
				us_cnt_r <= us_tick ? 8'h00 : us_cnt_r + 8'h01;
				if (us_tick) begin
					delay_cnt_r <= delay_cnt_r + 9'h001;
				end
				if (delay_hit) begin
					delay_run_r <= 1'b0;
				end
			end
		end
	end

	// ************************************************************
	// Channel outputs
	// ************************************************************
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			main_out_r <= 13'h0000;
			sub_out_r <= 13'h0000;
		end else begin
			main_out_r <= comp_clamp(main_meas, die_temp, nv_r[2], nv_r[0]);
			sub_out_r <= comp_clamp(sub_meas, die_temp, nv_r[3], nv_r[1]);
		end
	end

	assign main_out = main_out_r;
	assign sub_out = sub_out_r;
	assign frame_start = frame_start_r;
	assign frame_id_bit = nv_r[4][ID_BIT];
	assign slew_slow = nv_r[4][SLEW_BIT];
endmodule
`default_nettype wire

//--- tb/hall_output_config_properties.sv
// Concurrent property checker for the output configuration block
`timescale 1ns/1ps
`default_nettype none
module hall_output_config_properties
	import hall_cfg_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sync_pin,
	input wire logic prog_pulse_pin,
	input wire logic frame_id_bit,
	input wire logic slew_slow,
	input wire logic frame_start
);
	logic [15:0] since_sync_r;
	logic rd_w;
	logic bad_w;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// ************************************************************
	// Helper decode and counter
	// ************************************************************
	// Read access and unmapped word decode
	assign rd_w = psel && penable && !pwrite;
	assign bad_w = paddr > OFS_STATUS || paddr[1:0] != 2'h0;
	// Cycles since the raw sync pin rose, zero until one is seen
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			since_sync_r <= 16'h0000;
		end else if ($rose(sync_pin)) begin
			since_sync_r <= 16'h0001;
		end else if (since_sync_r != 16'h0000 && since_sync_r != 16'hFFFF) begin
			since_sync_r <= since_sync_r + 16'h0001;
		end
	end
	// ************************************************************
	// Properties
	// ************************************************************
	property p_frame_window;
		frame_start |-> since_sync_r >= 16'h2260 && since_sync_r <= 16'hE9A0;
	endproperty
	a_frame_window: assert property (p_frame_window) else $error("frame start outside delay span");
	property p_frame_pulse;
		frame_start |=> !frame_start;
	endproperty
	a_frame_pulse: assert property (p_frame_pulse) else $error("frame start longer than one cycle");
	property p_id_source;
		$changed(frame_id_bit) |-> prog_pulse_pin && $past(prog_pulse_pin, 2);
	endproperty
	a_id_source: assert property (p_id_source) else $error("id bit changed without burn");
	property p_slew_source;
		$changed(slew_slow) |-> prog_pulse_pin && $past(prog_pulse_pin, 2);
	endproperty
	a_slew_source: assert property (p_slew_source) else $error("edge rate changed without burn");
	property p_unmapped;
		rd_w && bad_w |-> pslverr && prdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
	property p_idle_data;
		!rd_w |-> prdata == 32'h0;
	endproperty
	a_idle_data: assert property (p_idle_data) else $error("read data outside read access");
	property p_err_phase;
		pslverr |-> psel && penable;
	endproperty
	a_err_phase: assert property (p_err_phase) else $error("error outside access phase");
	property p_cmd_read;
		rd_w && paddr == OFS_PROG_CMD |-> prdata == 32'h0 && !pslverr && pready;
	endproperty
	a_cmd_read: assert property (p_cmd_read) else $error("command word read not zero");
	property p_status_top;
		rd_w && paddr == OFS_STATUS |-> prdata[31:6] == 26'h0;
	endproperty
	a_status_top: assert property (p_status_top) else $error("status upper bits set");
endmodule
bind hall_output_config hall_output_config_properties hall_output_config_properties_inst (.clock, .nrst,
	.psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .sync_pin, .prog_pulse_pin,
	.frame_id_bit, .slew_slow, .frame_start);
`default_nettype wire

//--- tb/prog_station.sv
// Programming station and output receiver model
`timescale 1ns/1ps
`default_nettype none
module prog_station
#(
	parameter int PULSE_CYCLES = 40
) (
	input wire logic clock,
	input wire logic fire,
	input wire logic [12:0] rx_value,
	input wire logic [12:0] rx_low,
	input wire logic [12:0] rx_high,
	output logic pulse_pin,
	output logic rx_error
);
	int left = 0;
	// Pulse held a full scaled duration after each request
	always @(posedge clock) begin
		if (fire) begin
			left <= PULSE_CYCLES;
		end else if (left > 0) begin
			left <= left - 1;
		end
	end
	assign pulse_pin = left > 0;
	// Codes beyond the operating range count as errors
	assign rx_error = rx_value < rx_low || rx_value > rx_high;
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking testbench for the output configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench
	import hall_cfg_pkg::*;
;
	logic clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, sync_pin = 0, fire = 0;
	logic [7:0] paddr = 8'h00, die_temp = 8'h19;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, prog_pulse_pin, frame_id_bit, slew_slow, frame_start, rx_error;
	logic signed [13:0] main_meas = 14'sh0000, sub_meas = 14'sh0000;
	logic [12:0] main_out, sub_out;
	int fails = 0, comparisons = 0, cycles = 0;
	localparam logic [31:0] TW = TEMP_WORD_DEF | 32'h1FF3FF00;
	always #2.5 clock = ~clock;
	hall_output_config #(.ACTIVATE_WINDOW_CYCLES(200)) hall_output_config_inst (.clock, .nrst, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .main_meas, .sub_meas, .die_temp,
		.sync_pin, .prog_pulse_pin, .main_out, .sub_out, .frame_id_bit, .slew_slow, .frame_start);
	prog_station #(.PULSE_CYCLES(40)) prog_station_inst (.clock, .fire, .rx_value(main_out),
		.rx_low(13'h0064), .rx_high(13'h1F40), .pulse_pin(prog_pulse_pin), .rx_error);
	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic print_verdict;
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; mask selects compared read bits, error x skips its check
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [31:0] exp, input logic err);
		@(posedge clock);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		if (!w) cmp(prdata & m, exp);
		if (err !== 1'bx) cmp({31'h0, pslverr}, {31'h0, err});
		psel <= 0;
		penable <= 0;
	endtask
	task automatic cmd(input logic [2:0] c, input logic [1:0] pg, input logic err);
		apb(1, OFS_PROG_CMD, {26'h0, pg, 1'b0, c}, 0, 0, err);
	endtask
	task automatic pulse;
		@(posedge clock);
		fire <= 1;
		@(posedge clock);
		fire <= 0;
		repeat (45) @(posedge clock);
	endtask
	task automatic page(input logic [1:0] pg, input logic [7:0] a, input logic [31:0] w0, input logic [31:0] w1);
		cmd(CMD_PAGE_PROGRAM, pg, 0);
		apb(1, a, w0, 0, 0, 0);
		apb(1, 8'(a + 8'h04), w1, 0, 0, 0);
		cmd(CMD_PAGE_PROGRAM, pg, 0);
		pulse();
		apb(0, a, 0, '1, w0, 0);
		apb(0, 8'(a + 8'h04), 0, '1, w1, 0);
		apb(0, OFS_STATUS, 0, 32'h8, 32'h8, 0);
	endtask
	task automatic meas(input logic signed [13:0] m, input logic [12:0] em, input logic [12:0] es);
		@(posedge clock);
		main_meas <= m;
		sub_meas <= m;
		repeat (3) @(posedge clock);
		cmp(32'(main_out), 32'(em));
		cmp(32'(sub_out), 32'(es));
		cmp({31'h0, rx_error}, 0);
	endtask
	task automatic do_reset;
		nrst <= 0;
		repeat (8) @(posedge clock);
		nrst <= 1;
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_delay(input logic [7:0] code);
		int n;
		int exp;
		exp = (44 + code) * US_CYCLES;
		n = 0;
		@(posedge clock);
		sync_pin <= 1;
		do begin
			@(posedge clock);
			n++;
		end while (frame_start !== 1'b1);
		sync_pin <= 0;
		cmp({31'h0, n >= exp && n <= exp + 6}, 1);
	endtask
	task automatic t_late;
		repeat (210) @(posedge clock);
		cmd(CMD_ACTIVATE, 0, 1'bx);
		apb(0, OFS_STATUS, 0, 32'h1, 0, 0);
	endtask
	task automatic t_defaults;
		apb(0, OFS_MAIN_CLAMP, 0, '1, CLAMP_WORD_DEF, 0);
		apb(0, OFS_SUB_CLAMP, 0, '1, CLAMP_WORD_DEF, 0);
		apb(0, OFS_MAIN_TEMP, 0, '1, TEMP_WORD_DEF, 0);
		apb(0, OFS_PROTOCOL, 0, '1, PROTO_WORD_DEF, 0);
		apb(0, OFS_SUB_TEMP, 0, '1, TEMP_WORD_DEF, 0);
		apb(0, OFS_PROG_CMD, 0, '1, 0, 0);
		cmp({30'h0, frame_id_bit, slew_slow}, 32'h0);
		apb(0, 8'h20, 0, '1, 0, 1);
		apb(1, OFS_MAIN_CLAMP, 32'h0, 0, 0, 1);
		apb(0, OFS_STATUS, 0, '1, 32'h30, 0);
		apb(1, OFS_STATUS, 32'h10, 0, 0, 0);
		apb(0, OFS_STATUS, 0, '1, 32'h20, 0);
	endtask
	task automatic t_program;
		cmd(CMD_ACTIVATE, 0, 0);
		apb(0, OFS_STATUS, 0, 32'h1, 32'h1, 0);
		page(0, OFS_MAIN_CLAMP, 32'h1F400064, CLAMP_WORD_DEF);
		page(1, OFS_MAIN_TEMP, TW, TW);
		page(2, OFS_PROTOCOL, 32'h0000FF03, 32'hA5A55A5A);
		cmp({30'h0, frame_id_bit, slew_slow}, 32'h3);
		cmd(CMD_MARGIN, 0, 0);
		pulse();
		apb(0, OFS_STATUS, 0, 32'h4, 32'h4, 0);
		cmd(CMD_LOCK, 0, 0);
		pulse();
		apb(0, OFS_STATUS, 0, 32'h2, 32'h2, 0);
		cmd(CMD_PAGE_PROGRAM, 0, 1);
		apb(1, OFS_MAIN_CLAMP, 32'h0, 0, 0, 1);
		apb(0, OFS_MAIN_CLAMP, 0, '1, 32'h1F400064, 0);
		apb(0, OFS_STATUS, 0, 32'h10, 32'h10, 0);
		cmd(CMD_EXIT, 0, 0);
		apb(0, OFS_STATUS, 0, 32'h1, 32'h0, 0);
	endtask
	task automatic t_clamp;
		die_temp <= 8'd25;
		meas(14'sd8000, 13'd8000, 13'd7781);
		meas(-14'sd8000, 13'd100, 13'd409);
		meas(14'sd100, 13'd4195, 13'd4195);
	endtask
	task automatic t_temp;
		logic [12:0] e;
		e = 13'(4095 + (64'd1000 * (64'd8388608 + 708 * 100 * 64 + 255 * 100 * 100)) / 64'd8388608);
		die_temp <= 8'd125;
		meas(14'sd1000, e, e);
	endtask
	// ************************************************************
	// Main sequence and timeout
	// ************************************************************
	always @(posedge clock) begin
		cycles++;
		if (cycles == 90000) begin
			fails++;
			print_verdict();
		end
	end
	initial begin
		do_reset();
		t_delay(DELAY_DEF);
		t_late();
		do_reset();
		t_defaults();
		t_program();
		t_clamp();
		t_temp();
		t_delay(8'hFF);
		print_verdict();
	end
endmodule
`default_nettype wire
